// ===== verilog/rs_sequencer.sv
// Purpose: Reset sequencing, stabilisation counter, watchdog and interrupt arbitration
// Assumes: pclk 25 MHz; reference clock and pins are asynchronous and synchronised here
// Notes: Reference clock falling edges are detected after a two-flop synchroniser
// Functional notes
// RULE1 - Power-up holds reset pin low 4096 ticks
// RULE2 - Then 64 more ticks before CPU release
// RULE3 - Power-up: reset on, bus clock, CPU clocks off
// RULE4 - Power-up sets its flag, clears others
// RULE5 - Watchdog overflow resets, sets watchdog flag
// RULE6 - Internal resets drive reset pin low
// RULE7 - Top write clears watchdog, counter bits 12:4
// RULE8 - 13-bit counter on falling ref edge, clocks watchdog
// RULE9 - Watchdog disabled only by high-voltage pin logic
// RULE10 - Illegal instruction sets flag and resets
// RULE11 - Sleep with option clear is illegal opcode
// RULE12 - Only opcode fetch from unmapped address resets
// RULE13 - Undervoltage: flag, pin 4096, release 64 later
// RULE14 - Sleep instruction clears the counter
// RULE15 - Wake delay 32 or 4096 by option
// RULE16 - External pin reset keeps counter; internal clears
// RULE17 - Counter runs freely after every reset
// RULE18 - Entry stacks and masks; return restores
// RULE19 - Latched interrupt holds until serviced or unmasked
// RULE20 - Check at instruction end, mask and enable
// RULE21 - Highest priority first; pending served at return
// RULE22 - Software trap ignores mask, stacks current PC
// RULE23 - Resets equal priority above all interrupts; code orders power-up/undervoltage, then internal, then pin
// RULE24 - Internal reset: pin 32 ticks, then 32 more
// RULE25 - Every reset: internal reset, defaults, reset vector
// RULE26 - Reading cause register clears its flags
`timescale 1ns/100ps
`include "rs_regs.svh"

module rs_sequencer
	import rs_pkg::*;
(
	// System
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Asynchronous pins and monitors
	input wire logic osc_reference_clock,
	input wire logic reset_pin_in,
	output logic reset_pin_out,
	output logic reset_pin_oe,
	input wire logic power_up_pulse,
	input wire logic undervoltage_in,
	input wire logic hv_reset_pin,
	input wire logic hv_irq_pin,
	// CPU side, same clock
	input wire logic monitor_mode,
	input wire logic break_state,
	input wire logic top_write,
	input wire logic bad_opcode,
	input wire logic sleep_exec,
	input wire logic wake_req,
	input wire logic opcode_fetch,
	input wire logic unmapped_access,
	input wire logic insn_done,
	input wire logic trap_exec,
	input wire logic rti_exec,
	input wire logic int_ack,
	input wire logic global_mask,
	input wire logic [`RS_IRQ_N-1:0] irq_req,
	// Reset and clock control
	output logic internal_reset,
	output logic cpu_clk_en,
	output logic mod_clk_en,
	output logic bus_source_clock_en,
	// Interrupt control
	output logic int_take,
	output logic [`RS_VEC_W-1:0] vector_sel,
	output logic stack_pc_cur,
	output logic restore_req,
	output logic set_global_mask
);

	rs_state_t s_r;
	rs_state_t s_nxt;

	// Lowest index wins; used for vector choice only, the pending check is pend != 0
	function automatic logic [`RS_VEC_W-1:0] pick(input logic [`RS_IRQ_N-1:0] req);
		logic [`RS_VEC_W-1:0] v;
		v = `RS_VEC_NONE;
		for (int i = `RS_IRQ_N - 1; i >= 0; i--) begin
			if (req[i]) begin
				v = `RS_VEC_BASE + i[`RS_VEC_W-1:0];
			end
		end
		return v;
	endfunction

	function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
		return a == off;
	endfunction

	logic tick;
	logic ovf;
	logic wdog_off;
	logic wdog_ovf;
	logic opcode_err;
	logic fetch_err;
	logic por_evt;
	logic uv_evt;
	logic ext_evt;
	logic int_evt;
	logic in_reset;
	logic setup;
	logic access;
	logic mapped;
	logic [`RS_IRQ_N-1:0] pend;
	logic [7:0] cause_set;

	always_comb begin
		s_nxt = s_r;
		tick = s_r.osc_d & ~s_r.sy2[`RS_SY_OSC]; // [RULE8]
		ovf = tick && s_r.cnt == `RS_CNT_ALL;
		// Pure gating of pin levels, so noise cannot latch a disable
		wdog_off = (monitor_mode & (s_r.sy2[`RS_SY_HVRST] | s_r.sy2[`RS_SY_HVIRQ]))
			| (break_state & s_r.sy2[`RS_SY_HVRST]); // [RULE9]
		wdog_ovf = ovf && !wdog_off && s_r.wdog == `RS_WDOG_ALL; // [RULE5]
		in_reset = s_r.sq != SQ_RUN && s_r.sq != SQ_SLEEP && s_r.sq != SQ_WAKE;
		opcode_err = !in_reset && (bad_opcode
			|| (sleep_exec && !s_r.cfg[`RS_CFG_SLEEP_EN])); // [RULE10] [RULE11]
		fetch_err = !in_reset && unmapped_access && opcode_fetch; // [RULE12]
		por_evt = s_r.sy2[`RS_SY_POR];
		uv_evt = s_r.sy2[`RS_SY_UV] && s_r.sq != SQ_POWER;
		ext_evt = s_r.sq == SQ_RUN && !s_r.sy2[`RS_SY_PIN];
		int_evt = wdog_ovf || opcode_err || fetch_err;
		setup = psel && !penable;
		access = psel && penable && s_r.pready;
		mapped = hit(paddr, `RS_OFF_CAUSE) || hit(paddr, `RS_OFF_CONFIG)
			|| hit(paddr, `RS_OFF_IRQ_EN) || hit(paddr, `RS_OFF_STATUS);
		pend = irq_req & s_r.irq_en;
		cause_set = '0;

		// Pin synchronisers
		s_nxt.sy1 = {hv_irq_pin, hv_reset_pin, undervoltage_in, power_up_pulse,
			reset_pin_in, osc_reference_clock};
		s_nxt.sy2 = s_r.sy1;
		s_nxt.osc_d = s_r.sy2[`RS_SY_OSC];

		// Counter free-runs; prescales the watchdog
		if (tick) begin
			s_nxt.cnt = s_r.cnt + 1'b1; // [RULE17]
		end
		if (ovf && !wdog_off) begin
			s_nxt.wdog = s_r.wdog + 1'b1; // [RULE8]
		end
		if (top_write && !in_reset) begin
			s_nxt.cnt = s_nxt.cnt & `RS_SVC_MASK; // [RULE7]
			s_nxt.wdog = '0; // [RULE7]
		end
		if (tick && s_r.ph != '0) begin
			s_nxt.ph = s_r.ph - 1'b1;
		end

		// Sequencer
		unique case (s_r.sq)
			SQ_POWER: begin
				if (s_r.cnt >= `RS_CNT_LONG) begin
					s_nxt.sq = SQ_HOLD; // [RULE1] [RULE13]
					s_nxt.ph = `RS_HOLD_LONG; // [RULE2]
				end
			end
			SQ_DRIVE: begin
				if (tick && s_r.ph == 7'h01) begin
					s_nxt.sq = SQ_HOLD;
					s_nxt.ph = `RS_HOLD_SHORT; // [RULE24]
				end
			end
			SQ_HOLD: begin
				if (s_r.ph == '0) begin
					s_nxt.sq = SQ_RUN;
				end
			end
			SQ_EXT: begin
				if (s_r.sy2[`RS_SY_PIN]) begin
					s_nxt.sq = SQ_HOLD;
					s_nxt.ph = `RS_HOLD_LONG;
				end
			end
			SQ_RUN: begin
				if (sleep_exec && s_r.cfg[`RS_CFG_SLEEP_EN]) begin
					s_nxt.sq = SQ_SLEEP;
				end
			end
			SQ_SLEEP: begin
				s_nxt.cnt = '0; // [RULE14]
				s_nxt.wdog = s_r.wdog;
				if (wake_req) begin
					s_nxt.sq = SQ_WAKE;
					s_nxt.short_wake = s_r.cfg[`RS_CFG_SHORT_WAKE]; // [RULE15]
				end
			end
			SQ_WAKE: begin
				if (s_r.cnt >= (s_r.short_wake ? `RS_CNT_SHORT : `RS_CNT_LONG)) begin
					s_nxt.sq = SQ_RUN; // [RULE15]
				end
			end
		endcase

		// Resets are taken in order power-up/undervoltage, internal, pin, ahead of any interrupt
		if (por_evt || uv_evt) begin
			s_nxt.sq = SQ_POWER;
			s_nxt.cnt = '0; // [RULE16]
			s_nxt.wdog = '0;
			cause_set[`RS_CAUSE_UV] = uv_evt && !por_evt; // [RULE13]
		end else if (int_evt) begin
			s_nxt.sq = SQ_DRIVE; // [RULE6] [RULE23]
			s_nxt.ph = `RS_DRIVE_LEN; // [RULE24]
			s_nxt.cnt = '0; // [RULE16]
			s_nxt.wdog = '0;
			cause_set[`RS_CAUSE_WDOG] = wdog_ovf; // [RULE5]
			cause_set[`RS_CAUSE_OPCODE] = opcode_err; // [RULE10]
			cause_set[`RS_CAUSE_FETCH] = fetch_err; // [RULE12]
		end else if (ext_evt) begin
			s_nxt.sq = SQ_EXT; // Counter untouched [RULE16]
			cause_set[`RS_CAUSE_PIN] = 1'b1;
		end

		// APB: no wait cycle, answer registered at setup
		s_nxt.pready = setup;
		if (setup) begin
			s_nxt.pslverr = !mapped;
			s_nxt.prdata = '0;
			if (hit(paddr, `RS_OFF_CAUSE)) begin
				s_nxt.prdata[7:0] = s_r.cause;
			end
			if (hit(paddr, `RS_OFF_CONFIG)) begin
				s_nxt.prdata[1:0] = s_r.cfg;
			end
			if (hit(paddr, `RS_OFF_IRQ_EN)) begin
				s_nxt.prdata[`RS_IRQ_N-1:0] = s_r.irq_en;
			end
			if (hit(paddr, `RS_OFF_STATUS)) begin
				s_nxt.prdata[`RS_CNT_W-1:0] = s_r.cnt;
				s_nxt.prdata[18:16] = s_r.sq;
				s_nxt.prdata[31:24] = s_r.wdog;
			end
		end else if (!psel) begin
			s_nxt.pslverr = 1'b0;
		end
		if (access && pwrite && hit(paddr, `RS_OFF_CONFIG)) begin
			s_nxt.cfg = pwdata[1:0];
		end
		if (access && pwrite && hit(paddr, `RS_OFF_IRQ_EN)) begin
			s_nxt.irq_en = pwdata[`RS_IRQ_N-1:0];
		end
		if (access && !pwrite && hit(paddr, `RS_OFF_CAUSE)) begin
			s_nxt.cause = '0; // [RULE26]
		end
		// New cause beats a read clear in the same cycle
		s_nxt.cause = s_nxt.cause | cause_set;
		if (por_evt) begin
			s_nxt.cause = 8'h00;
			s_nxt.cause[`RS_CAUSE_POWER] = 1'b1; // [RULE4]
		end

		// Interrupt arbitration
		s_nxt.int_take = 1'b0;
		s_nxt.restore = !in_reset && rti_exec; // [RULE18]
		if (s_r.latched && (int_ack || !global_mask)) begin
			s_nxt.latched = 1'b0; // [RULE19]
		end
		if (!in_reset && insn_done && !s_r.latched) begin // [RULE20]
			if (trap_exec) begin
				s_nxt.int_take = 1'b1; // [RULE22]
				s_nxt.latched = 1'b1;
				s_nxt.vec = `RS_VEC_TRAP;
				s_nxt.stack_pc_cur = 1'b1; // [RULE22]
			end else if (!global_mask && pend != '0) begin
				s_nxt.int_take = 1'b1; // [RULE18]
				s_nxt.latched = 1'b1; // [RULE19]
				s_nxt.vec = pick(pend); // [RULE21]
				s_nxt.stack_pc_cur = 1'b0;
			end
		end

		// Interrupt enables, latch, take, restore and vector return to defaults in reset
		if (s_nxt.sq == SQ_POWER || s_nxt.sq == SQ_DRIVE || s_nxt.sq == SQ_HOLD
			|| s_nxt.sq == SQ_EXT) begin
			s_nxt.irq_en = '0; // [RULE25]
			s_nxt.latched = 1'b0;
			s_nxt.int_take = 1'b0; // [RULE23]
			s_nxt.restore = 1'b0;
			s_nxt.vec = `RS_VEC_RESET; // [RULE25]
		end

		// Outputs follow the next sequencer state
		s_nxt.internal_reset = s_nxt.sq == SQ_POWER || s_nxt.sq == SQ_DRIVE
			|| s_nxt.sq == SQ_HOLD || s_nxt.sq == SQ_EXT; // [RULE25]
		s_nxt.pin_oe = s_nxt.sq == SQ_POWER || s_nxt.sq == SQ_DRIVE; // [RULE1] [RULE6]
		s_nxt.cpu_clk_en = s_nxt.sq == SQ_RUN; // [RULE2]
		s_nxt.mod_clk_en = s_nxt.sq != SQ_POWER && s_nxt.sq != SQ_SLEEP
			&& s_nxt.sq != SQ_WAKE; // [RULE3]
		s_nxt.bus_src_clk_en = s_nxt.sq != SQ_SLEEP; // [RULE3]

		if (!ce) begin
			s_nxt = s_r;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_r <= '0;
			s_r.sq <= SQ_POWER; // [RULE3]
			s_r.cause <= 8'h80; // [RULE4]
			s_r.cfg <= `RS_CFG_RESET;
			s_r.vec <= `RS_VEC_RESET;
			s_r.internal_reset <= 1'b1;
			s_r.pin_oe <= 1'b1;
			s_r.bus_src_clk_en <= 1'b1;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign prdata = s_r.prdata;
	assign pready = s_r.pready;
	assign pslverr = s_r.pslverr;
	assign reset_pin_out = 1'b0;
	assign reset_pin_oe = s_r.pin_oe;
	assign internal_reset = s_r.internal_reset;
	assign cpu_clk_en = s_r.cpu_clk_en;
	assign mod_clk_en = s_r.mod_clk_en;
	assign bus_source_clock_en = s_r.bus_src_clk_en;
	assign int_take = s_r.int_take;
	assign vector_sel = s_r.vec;
	assign stack_pc_cur = s_r.stack_pc_cur;
	assign restore_req = s_r.restore;
	assign set_global_mask = s_r.int_take;

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	a_power_clocks: assert property (s_r.sq == SQ_POWER |-> // [RULE3]
		s_r.pin_oe && !s_r.cpu_clk_en && s_r.bus_src_clk_en)
		else $error("power count must drive pin and stop cpu clock");
	a_drive_pin: assert property (s_r.sq == SQ_DRIVE |-> // [RULE6]
		s_r.pin_oe && s_r.internal_reset)
		else $error("internal reset must drive the pin");
	a_run_release: assert property (s_r.sq == SQ_RUN |-> // [RULE25]
		!s_r.internal_reset && !s_r.pin_oe && s_r.cpu_clk_en)
		else $error("run state must release reset");
	a_wdog_cause: assert property (ce && wdog_ovf && !por_evt && !uv_evt |=> // [RULE5]
		s_r.sq == SQ_DRIVE && s_r.cause[`RS_CAUSE_WDOG])
		else $error("watchdog overflow must reset and flag");
	a_power_flag: assert property (ce && por_evt |=> s_r.cause == 8'h80) // [RULE4]
		else $error("power-up must leave only its flag");
	a_bad_sleep: assert property (ce && s_r.sq == SQ_RUN && sleep_exec // [RULE11]
		&& !s_r.cfg[`RS_CFG_SLEEP_EN] && !por_evt && !uv_evt |=>
		s_r.cause[`RS_CAUSE_OPCODE] && s_r.sq == SQ_DRIVE)
		else $error("disabled sleep must be an illegal opcode");
	a_data_access: assert property (ce && s_r.sq == SQ_RUN && unmapped_access // [RULE12]
		&& !opcode_fetch && !bad_opcode && !sleep_exec && !wdog_ovf && !por_evt
		&& !uv_evt && !ext_evt |=> s_r.sq == SQ_RUN)
		else $error("data access must not reset");
	a_trap_taken: assert property (ce && !in_reset && insn_done && trap_exec // [RULE22]
		&& !s_r.latched && global_mask && !int_evt && !por_evt && !uv_evt && !ext_evt
		|=> s_r.int_take && s_r.vec == `RS_VEC_TRAP && s_r.stack_pc_cur)
		else $error("trap must be taken despite mask");
	a_mask_blocks: assert property (ce && insn_done && global_mask && !trap_exec // [RULE20]
		|=> !s_r.int_take)
		else $error("masked interrupt was taken");
	a_service_clear: assert property (ce && top_write && !in_reset && s_r.sq != SQ_SLEEP
		&& !int_evt && !por_evt && !uv_evt |=> // [RULE7]
		s_r.cnt[`RS_CNT_W-1:4] == '0 && s_r.wdog == '0)
		else $error("service write must clear counters");
	a_wdog_gate: assert property (ce && wdog_off && !top_write && !int_evt // [RULE9]
		&& !por_evt && !uv_evt |=> $stable(s_r.wdog))
		else $error("disabled watchdog must not count");

endmodule

// ===== include/rs_regs.svh
// Purpose: Register offsets, field positions and timing counts of the reset sequencer
// Assumes: APB with 32-bit data, one aligned word per register
// Notes: Timing counts are in reference clock falling edges
`ifndef RS_REGS_SVH
`define RS_REGS_SVH

// Register byte offsets
`define RS_OFF_CAUSE 8'h00
`define RS_OFF_CONFIG 8'h04
`define RS_OFF_IRQ_EN 8'h08
`define RS_OFF_STATUS 8'h0c

// Reset cause register bits
`define RS_CAUSE_POWER 7
`define RS_CAUSE_PIN 6
`define RS_CAUSE_WDOG 5
`define RS_CAUSE_OPCODE 4
`define RS_CAUSE_FETCH 3
`define RS_CAUSE_UV 1

// Config register bits
`define RS_CFG_SLEEP_EN 0
`define RS_CFG_SHORT_WAKE 1
`define RS_CFG_RESET 2'h0

// Stabilisation counter
`define RS_CNT_W 13
`define RS_CNT_LONG 13'h1000
`define RS_CNT_SHORT 13'h0020
`define RS_CNT_ALL 13'h1fff
`define RS_SVC_MASK 13'h000f

// Phase counts while the pin is driven and after it is released
`define RS_PH_W 7
`define RS_HOLD_LONG 7'h40
`define RS_HOLD_SHORT 7'h20
`define RS_DRIVE_LEN 7'h20

// Watchdog counter
`define RS_WDOG_W 8
`define RS_WDOG_ALL 8'hff

// Interrupts
`define RS_IRQ_N 8
`define RS_VEC_W 4
`define RS_VEC_RESET 4'hf
`define RS_VEC_TRAP 4'he
`define RS_VEC_NONE 4'h0
`define RS_VEC_BASE 4'h1

// Synchronised pins: ref clock, reset pin, power-up, undervoltage, high volt rst, high volt irq
`define RS_SYNC_N 6
`define RS_SY_OSC 0
`define RS_SY_PIN 1
`define RS_SY_POR 2
`define RS_SY_UV 3
`define RS_SY_HVRST 4
`define RS_SY_HVIRQ 5

`endif

// ===== include/rs_pkg.sv
// Purpose: Types of the reset sequencer
// Assumes: rs_regs.svh gives the widths
// Notes: Whole module state is one packed struct
`include "rs_regs.svh"

package rs_pkg;

	typedef enum logic [2:0] {
		SQ_POWER,
		SQ_DRIVE,
		SQ_HOLD,
		SQ_EXT,
		SQ_RUN,
		SQ_SLEEP,
		SQ_WAKE
	} rs_seq_t;

	typedef struct packed {
		logic [`RS_SYNC_N-1:0] sy1;
		logic [`RS_SYNC_N-1:0] sy2;
		logic osc_d;
		rs_seq_t sq;
		logic [`RS_CNT_W-1:0] cnt;
		logic [`RS_PH_W-1:0] ph;
		logic long_hold;
		logic short_wake;
		logic [`RS_WDOG_W-1:0] wdog;
		logic [7:0] cause;
		logic [1:0] cfg;
		logic [`RS_IRQ_N-1:0] irq_en;
		logic latched;
		logic [`RS_VEC_W-1:0] vec;
		logic int_take;
		logic stack_pc_cur;
		logic restore;
		logic internal_reset;
		logic pin_oe;
		logic cpu_clk_en;
		logic mod_clk_en;
		logic bus_src_clk_en;
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
	} rs_state_t;

endpackage

// ===== tb/rs_far_model.sv
// Purpose: Far-side model: reference oscillator and open-drain reset pin
// Assumes: HALF pclk cycles per half period, at least three for the synchroniser
// Notes: Runs free; the pin has a pull-up, so a released pin reads high
`timescale 1ns/100ps

module rs_far_model #(
	parameter int HALF = 3
) (
	// Clock
	input wire logic pclk,
	// Reset pin
	input wire logic reset_pin_oe,
	input wire logic reset_pin_out,
	input wire logic ext_hold,
	output logic reset_pin_in,
	// Oscillator
	output logic osc_reference_clock
);
	int n = 0;

	initial osc_reference_clock = 1'b1;

	// Ticks change only after pclk edges, so the synchroniser never sees a glitch
	always @(posedge pclk) begin
		if (n == HALF - 1) begin
			n <= 0;
			osc_reference_clock <= ~osc_reference_clock;
		end else begin
			n <= n + 1;
		end
	end

	// Wired-AND: device or outside party can pull low
	assign reset_pin_in = ~((reset_pin_oe & ~reset_pin_out) | ext_hold);
endmodule

// ===== tb/testbench.sv
// Purpose: Self-checking bench for the reset sequencer
// Assumes: One reference tick is 6 pclk cycles
// Notes: Long resets dominate run time; watchdog overflow is too slow to reach
`timescale 1ns/100ps
`include "rs_regs.svh"

module testbench;
	import rs_pkg::*;
	localparam int T = 6;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, ext_hold;
	logic hv_reset_pin, hv_irq_pin, monitor_mode, break_state;
	logic [7:0] paddr, irq_req;
	logic [31:0] pwdata, prdata;
	logic osc_reference_clock, reset_pin_in, reset_pin_out, reset_pin_oe;
	logic power_up_pulse, undervoltage_in, top_write, bad_opcode, sleep_exec, wake_req;
	logic opcode_fetch, unmapped_access, insn_done, trap_exec, rti_exec, int_ack, global_mask;
	logic internal_reset, cpu_clk_en, mod_clk_en, bus_source_clock_en;
	logic int_take, stack_pc_cur, restore_req, set_global_mask;
	logic [3:0] vector_sel;
	logic [32:0] q[$];
	logic [7:0] cz[5] = '{8'h10, 8'h10, 8'h08, 8'h02, 8'h80};
	int fail_count = 0;
	int checks_done = 0;
	int cyc = 0;
	int n;

	rs_sequencer rs_sequencer_inst (.pclk, .presetn, .ce(1'b1), .psel, .penable, .pwrite,
		.paddr, .pwdata, .prdata, .pready, .pslverr, .osc_reference_clock, .reset_pin_in,
		.reset_pin_out, .reset_pin_oe, .power_up_pulse, .undervoltage_in, .hv_reset_pin,
		.hv_irq_pin, .monitor_mode, .break_state, .top_write, .bad_opcode,
		.sleep_exec, .wake_req, .opcode_fetch, .unmapped_access, .insn_done, .trap_exec,
		.rti_exec, .int_ack, .global_mask, .irq_req, .internal_reset, .cpu_clk_en, .mod_clk_en,
		.bus_source_clock_en, .int_take, .vector_sel, .stack_pc_cur, .restore_req,
		.set_global_mask);
	rs_far_model #(.HALF(T / 2)) rs_far_model_inst (.pclk, .reset_pin_oe, .reset_pin_out,
		.ext_hold, .reset_pin_in, .osc_reference_clock);

	task automatic chk(input string s, input logic [32:0] e, input logic [32:0] v);
		checks_done++;
		if (v !== e) begin
			fail_count++;
			$display("mismatch %s expected %h seen %h", s, e, v);
		end
	endtask

	task automatic conclude();
		$display("checks %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	// Synchroniser latency differs per edge, so allow one tick
	function automatic logic near(input int c, input int e);
		return (c - e <= T) && (e - c <= T);
	endfunction

	function automatic logic busy(input int w);
		return w == 0 ? reset_pin_oe : w == 1 ? internal_reset : !cpu_clk_en;
	endfunction

	task automatic span(input int w, output int c);
		c = 0;
		while (busy(w) === 1'b1) begin
			@(posedge pclk);
			c++;
		end
	endtask

	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1;
		penable <= 0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		do @(posedge pclk); while (pready !== 1'b1);
		psel <= 0;
		penable <= 0;
		@(posedge pclk);
	endtask

	task automatic rd(input logic [7:0] a, input logic [32:0] e);
		q.push_back(e);
		apb(0, a, 32'h0);
	endtask

	task automatic pulse_gap();
		@(posedge pclk);
		{bad_opcode, sleep_exec, wake_req, opcode_fetch, unmapped_access} <= 5'h0;
		{power_up_pulse, undervoltage_in, top_write, insn_done, trap_exec} <= 5'h0;
	endtask

	task automatic seq(input int lp, input int lr, input logic [7:0] cause);
		while (reset_pin_oe !== 1'b1) @(posedge pclk);
		span(0, n);
		chk("pin low span", 1, near(n, lp * T));
		chk("cpu clock held", 0, cpu_clk_en);
		chk("pin data", 0, reset_pin_out);
		span(1, n);
		chk("reset tail", 1, near(n, lr * T));
		rd(`RS_OFF_CAUSE, cause);
		rd(`RS_OFF_CAUSE, 33'h0);
	endtask

	task automatic step(input logic t, input logic m);
		logic [7:0] r;
		int v;
		r = 8'($urandom);
		if (r == 8'h00)
			r = 8'h80;
		v = 0;
		for (int j = 7; j >= 0; j--)
			if (r[j])
				v = j + 1;
		if (t)
			q.push_back({28'h0, `RS_VEC_TRAP, 1'b1});
		else if (!m)
			q.push_back({28'h0, 4'(v), 1'b0});
		irq_req <= r;
		global_mask <= m;
		@(posedge pclk);
		insn_done <= 1;
		trap_exec <= t;
		pulse_gap();
		repeat (3) @(posedge pclk);
		int_ack <= 1;
		rti_exec <= 1;
		@(posedge pclk);
		{int_ack, rti_exec} <= 2'b0;
		@(negedge pclk);
		chk("restore", 1, restore_req);
		@(posedge pclk);
	endtask

	initial begin
		pclk = 0;
		forever #20 pclk = ~pclk;
	end

	always @(posedge pclk) begin
		cyc++;
		if (cyc == 95000) begin
			fail_count++;
			conclude();
		end
	end

	// Watcher: oldest note against each answer that appears
	task automatic cmp(input logic [32:0] v);
		if (q.size() == 0)
			chk("unexpected result", 0, 1);
		else
			chk("result", q.pop_front(), v);
	endtask

	always @(posedge pclk) begin
		if (psel && penable && pready === 1'b1 && !pwrite)
			cmp({pslverr, prdata});
		if (int_take === 1'b1) begin
			cmp({28'h0, vector_sel, stack_pc_cur});
			chk("mask set", 1, set_global_mask);
		end
	end

	initial begin
		{presetn, psel, penable, pwrite, ext_hold, rti_exec, int_ack, global_mask} = 0;
		{bad_opcode, sleep_exec, wake_req, opcode_fetch, unmapped_access} = 0;
		{power_up_pulse, undervoltage_in, top_write, insn_done, trap_exec} = 0;
		{hv_reset_pin, hv_irq_pin, monitor_mode, break_state} = 0;
		paddr = 0;
		pwdata = 0;
		irq_req = 0;
		n = $urandom(2);
		repeat (2) @(posedge pclk);
		chk("reset outputs", 5'b11001, {internal_reset, reset_pin_oe, cpu_clk_en, mod_clk_en,
			bus_source_clock_en});
		chk("reset vector", `RS_VEC_RESET, vector_sel);
		presetn <= 1;
		seq(4096, 64, 8'h80);
		rd(8'h10, {1'b1, 32'h0});
		apb(1, `RS_OFF_IRQ_EN, 32'hff);
		rd(`RS_OFF_IRQ_EN, 33'hff);
		top_write <= 1;
		pulse_gap();
		{monitor_mode, hv_irq_pin} <= 2'b11;
		for (int i = 0; i < 6; i++)
			step(i % 3 == 0, i % 3 != 2);
		{monitor_mode, hv_irq_pin, break_state, hv_reset_pin} <= 4'b0011;
		// Bad opcode, sleep while disabled, bad fetch, undervoltage, power-up
		for (int s = 0; s < 5; s++) begin
			{power_up_pulse, undervoltage_in, opcode_fetch, sleep_exec, bad_opcode} <= 5'(1 << s);
			unmapped_access <= (s == 2);
			pulse_gap();
			seq(s > 2 ? 4096 : 32, s > 2 ? 64 : 32, cz[s]);
		end
		unmapped_access <= 1;
		pulse_gap();
		repeat (20) @(posedge pclk);
		chk("data access reset", 0, reset_pin_oe);
		apb(1, `RS_OFF_CONFIG, 32'h3);
		sleep_exec <= 1;
		pulse_gap();
		repeat (4 * T) @(posedge pclk);
		chk("sleep clocks", 3'b000, {cpu_clk_en, mod_clk_en, bus_source_clock_en});
		rd(`RS_OFF_STATUS, 33'h0_0005_0000);
		wake_req <= 1;
		pulse_gap();
		span(2, n);
		chk("short wake", 1, near(n, 32 * T));
		ext_hold <= 1;
		repeat (70 * T) @(posedge pclk);
		chk("pin reset", 1, internal_reset);
		ext_hold <= 0;
		@(posedge pclk);
		span(1, n);
		chk("pin tail", 1, near(n, 64 * T));
		rd(`RS_OFF_CAUSE, 33'h40);
		repeat (4) @(posedge pclk);
		chk("queue drained", 0, q.size());
		conclude();
	end
endmodule
